// File: design/tarb_defines.svh
`ifndef TARB_DEFINES_SVH
`define TARB_DEFINES_SVH

// register byte addresses
`define TARB_ADDR_TREBLE_CORNER_LO 8'h77
`define TARB_ADDR_TREBLE_CORNER_HI 8'h78
`define TARB_ADDR_BASS_CORNER_LO 8'h79
`define TARB_ADDR_BASS_CORNER_HI 8'h7A
`define TARB_ADDR_TREBLE_GAIN 8'h7B
`define TARB_ADDR_BASS_GAIN 8'h7C
`define TARB_ADDR_HEADROOM_ATTEN 8'h7D
`define TARB_ADDR_AUX_BYTE_FIRST 8'h7E
`define TARB_ADDR_AUX_BYTE_LAST 8'hB5
`define TARB_ADDR_AUX_READY_STATUS 8'hB6
`define TARB_ADDR_ADPCM_SETUP 8'hB8
`define TARB_ADDR_AUX_BITCOUNT_LO 8'hF0
`define TARB_ADDR_AUX_BITCOUNT_HI 8'hF1

// buffer size and field positions
`define TARB_AUX_BYTES 56
`define TARB_READY_BIT 0
`define TARB_FRAMED_BIT 0
`define TARB_STEREO_BIT 1
`define TARB_CODEC_LO_BIT 2
`define TARB_CODEC_HI_BIT 3

// reset values
`define TARB_RESET_BYTE 8'h00
`define TARB_RESET_COUNT 16'h0000

// gain limits in 1.5 dB steps
`define TARB_GAIN_MAX 8'sh0C
`define TARB_GAIN_MIN (-8'sh0C)
`define TARB_ATTEN_MAX 8'h0C

`endif

// File: design/tarb_pkg.sv
`default_nettype none
package tarb_pkg;
  // coder choices of the two-bit algorithm field
  typedef enum logic [1:0] {
    TARB_CODEC_ADAPTIVE = 2'h0,
    TARB_CODEC_24K = 2'h1,
    TARB_CODEC_32K = 2'h2,
    TARB_CODEC_40K = 2'h3
  } tarb_codec_type;
endpackage : tarb_pkg
`default_nettype wire

// File: design/tarb_regs.sv
// Overview of operation
// - treble corner: 16-bit unsigned hertz value
// - bass corner: 16-bit unsigned hertz value
// - treble gain signed, 1.5 dB steps, +-18
// - bass gain signed, 1.5 dB steps, +-18
// - headroom unsigned 1.5 dB steps, 0..18 dB
// - 56 read-only ancillary bytes at 0x7E-0xB5
// - low/high registers report ancillary bit count
// - ready flag one when block pending
// - bit zero selects framed or raw output
// - bit one selects stereo or mono
// - two-bit field selects ADPCM algorithm
`timescale 1ns/1ps
`default_nettype none
`include "tarb_defines.svh"

module tarb_regs (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port from the control bus engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // ancillary block load from the decoder core
  input wire logic aux_load,
  input wire logic [5:0] aux_load_index,
  input wire logic [7:0] aux_load_byte,
  input wire logic aux_block_done,
  input wire logic [15:0] aux_block_bits,
  // equaliser settings
  output logic [15:0] treble_corner_bits,
  output logic [15:0] bass_corner_bits,
  output logic signed [7:0] treble_gain_bits,
  output logic signed [7:0] bass_gain_bits,
  output logic [7:0] headroom_bits,
  // ancillary status
  output logic aux_ready,
  // adpcm configuration
  output logic framed_output_on,
  output logic stereo_coding_on,
  output tarb_pkg::tarb_codec_type codec_select
);
  import tarb_pkg::*;

  // stored register bytes
  logic [7:0] treble_lo_q;
  logic [7:0] treble_hi_q;
  logic [7:0] bass_lo_q;
  logic [7:0] bass_hi_q;
  logic [7:0] treble_gain_q;
  logic [7:0] bass_gain_q;
  logic [7:0] headroom_q;
  logic [7:0] setup_q;

  // ancillary buffer, bit count and ready flag
  logic [7:0] aux_mem_q [`TARB_AUX_BYTES];
  logic [`TARB_AUX_BYTES-1:0] aux_slot_wr;
  logic [15:0] bitcount_q;
  logic ready_q;

  // write strobes, one per writable register
  logic wr_treble_lo;
  logic wr_treble_hi;
  logic wr_bass_lo;
  logic wr_bass_hi;
  logic wr_treble_gain;
  logic wr_bass_gain;
  logic wr_headroom;
  logic wr_status;
  logic wr_setup;
  logic wr_ready_zero;

  // read side
  logic rd_in_aux;
  logic [5:0] rd_aux_index;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  // next values of the settings outputs
  logic [15:0] treble_corner_d;
  logic [15:0] bass_corner_d;
  logic signed [7:0] treble_gain_d;
  logic signed [7:0] bass_gain_d;
  logic [7:0] headroom_d;

  // saturate a signed step count
  function automatic logic signed [7:0] clamp_gain(input logic [7:0] raw);
    logic signed [7:0] v;
    v = signed'(raw);
    if (v > `TARB_GAIN_MAX) begin
      return `TARB_GAIN_MAX;
    end
    if (v < `TARB_GAIN_MIN) begin
      return `TARB_GAIN_MIN;
    end
    return v;
  endfunction : clamp_gain

  // address decode of host writes
  assign wr_treble_lo = reg_wr && (reg_addr == `TARB_ADDR_TREBLE_CORNER_LO);
  assign wr_treble_hi = reg_wr && (reg_addr == `TARB_ADDR_TREBLE_CORNER_HI);
  assign wr_bass_lo = reg_wr && (reg_addr == `TARB_ADDR_BASS_CORNER_LO);
  assign wr_bass_hi = reg_wr && (reg_addr == `TARB_ADDR_BASS_CORNER_HI);
  assign wr_treble_gain = reg_wr && (reg_addr == `TARB_ADDR_TREBLE_GAIN);
  assign wr_bass_gain = reg_wr && (reg_addr == `TARB_ADDR_BASS_GAIN);
  assign wr_headroom = reg_wr && (reg_addr == `TARB_ADDR_HEADROOM_ATTEN);
  assign wr_status = reg_wr && (reg_addr == `TARB_ADDR_AUX_READY_STATUS);
  assign wr_setup = reg_wr && (reg_addr == `TARB_ADDR_ADPCM_SETUP);

  // a zero written to the ready bit is the host's clear; a one does nothing
  assign wr_ready_zero = wr_status && !reg_wdata[`TARB_READY_BIT];

  // treble corner, low byte
  always_ff @(posedge clk) begin
    if (srst) begin
      treble_lo_q <= `TARB_RESET_BYTE;
    end else if (wr_treble_lo) begin
      treble_lo_q <= reg_wdata;
    end
  end

  // treble corner, high byte
  always_ff @(posedge clk) begin
    if (srst) begin
      treble_hi_q <= `TARB_RESET_BYTE;
    end else if (wr_treble_hi) begin
      treble_hi_q <= reg_wdata;
    end
  end

  // bass corner, low byte
  always_ff @(posedge clk) begin
    if (srst) begin
      bass_lo_q <= `TARB_RESET_BYTE;
    end else if (wr_bass_lo) begin
      bass_lo_q <= reg_wdata;
    end
  end

  // bass corner, high byte
  always_ff @(posedge clk) begin
    if (srst) begin
      bass_hi_q <= `TARB_RESET_BYTE;
    end else if (wr_bass_hi) begin
      bass_hi_q <= reg_wdata;
    end
  end

  // treble gain, stored raw and clamped on the way out
  always_ff @(posedge clk) begin
    if (srst) begin
      treble_gain_q <= `TARB_RESET_BYTE;
    end else if (wr_treble_gain) begin
      treble_gain_q <= reg_wdata;
    end
  end

  // bass gain, stored raw and clamped on the way out
  always_ff @(posedge clk) begin
    if (srst) begin
      bass_gain_q <= `TARB_RESET_BYTE;
    end else if (wr_bass_gain) begin
      bass_gain_q <= reg_wdata;
    end
  end

  // headroom attenuation byte
  always_ff @(posedge clk) begin
    if (srst) begin
      headroom_q <= `TARB_RESET_BYTE;
    end else if (wr_headroom) begin
      headroom_q <= reg_wdata;
    end
  end

  // coder setup, upper four bits are not stored
  always_ff @(posedge clk) begin
    if (srst) begin
      setup_q <= `TARB_RESET_BYTE;
    end else if (wr_setup) begin
      setup_q <= {4'h0, reg_wdata[3:0]};
    end
  end

  // ancillary byte store, written only by the decoder
  for (genvar i = 0; i < `TARB_AUX_BYTES; i++) begin : g_aux
    assign aux_slot_wr[i] = aux_load && (aux_load_index == 6'(i));

    // one byte slot, read-only to the host
    always_ff @(posedge clk) begin
      if (srst) begin
        aux_mem_q[i] <= `TARB_RESET_BYTE;
      end else if (aux_slot_wr[i]) begin
        aux_mem_q[i] <= aux_load_byte;
      end
    end
  end

  // bit count latched when a block completes
  always_ff @(posedge clk) begin
    if (srst) begin
      bitcount_q <= `TARB_RESET_COUNT;
    end else if (aux_block_done) begin
      bitcount_q <= aux_block_bits;
    end
  end

  // ready flag: a new block wins over a host clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      ready_q <= 1'b0;
    end else if (aux_block_done) begin
      ready_q <= 1'b1;
    end else if (wr_ready_zero) begin
      ready_q <= 1'b0;
    end
  end

  // the ancillary window is one contiguous address range
  assign rd_in_aux = (reg_addr >= `TARB_ADDR_AUX_BYTE_FIRST) && (reg_addr <= `TARB_ADDR_AUX_BYTE_LAST);
  assign rd_aux_index = 6'(reg_addr - `TARB_ADDR_AUX_BYTE_FIRST);

  // read multiplexer, unmapped addresses read zero
  always_comb begin
    rdata_d = `TARB_RESET_BYTE;
    if (rd_in_aux) begin
      rdata_d = aux_mem_q[rd_aux_index];
    end else begin
      unique case (reg_addr)
        `TARB_ADDR_TREBLE_CORNER_LO: rdata_d = treble_lo_q;
        `TARB_ADDR_TREBLE_CORNER_HI: rdata_d = treble_hi_q;
        `TARB_ADDR_BASS_CORNER_LO: rdata_d = bass_lo_q;
        `TARB_ADDR_BASS_CORNER_HI: rdata_d = bass_hi_q;
        `TARB_ADDR_TREBLE_GAIN: rdata_d = treble_gain_q;
        `TARB_ADDR_BASS_GAIN: rdata_d = bass_gain_q;
        `TARB_ADDR_HEADROOM_ATTEN: rdata_d = headroom_q;
        `TARB_ADDR_AUX_READY_STATUS: rdata_d = {7'h00, ready_q};
        `TARB_ADDR_ADPCM_SETUP: rdata_d = setup_q;
        `TARB_ADDR_AUX_BITCOUNT_LO: rdata_d = bitcount_q[7:0];
        `TARB_ADDR_AUX_BITCOUNT_HI: rdata_d = bitcount_q[15:8];
        default: rdata_d = `TARB_RESET_BYTE;
      endcase
    end
  end

  // read data held until the next read strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= `TARB_RESET_BYTE;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  // corner frequencies are the two bytes side by side
  assign treble_corner_d = {treble_hi_q, treble_lo_q};
  assign bass_corner_d = {bass_hi_q, bass_lo_q};

  // gains saturate at +-12 steps of 1.5 dB
  assign treble_gain_d = clamp_gain(treble_gain_q);
  assign bass_gain_d = clamp_gain(bass_gain_q);

  // headroom saturates at 12 steps of 1.5 dB
  assign headroom_d = (headroom_q > `TARB_ATTEN_MAX) ? `TARB_ATTEN_MAX : headroom_q;

  // treble corner to the equaliser
  always_ff @(posedge clk) begin
    if (srst) begin
      treble_corner_bits <= `TARB_RESET_COUNT;
    end else begin
      treble_corner_bits <= treble_corner_d;
    end
  end

  // bass corner to the equaliser
  always_ff @(posedge clk) begin
    if (srst) begin
      bass_corner_bits <= `TARB_RESET_COUNT;
    end else begin
      bass_corner_bits <= bass_corner_d;
    end
  end

  // treble gain to the equaliser
  always_ff @(posedge clk) begin
    if (srst) begin
      treble_gain_bits <= `TARB_RESET_BYTE;
    end else begin
      treble_gain_bits <= treble_gain_d;
    end
  end

  // bass gain to the equaliser
  always_ff @(posedge clk) begin
    if (srst) begin
      bass_gain_bits <= `TARB_RESET_BYTE;
    end else begin
      bass_gain_bits <= bass_gain_d;
    end
  end

  // headroom to the equaliser
  always_ff @(posedge clk) begin
    if (srst) begin
      headroom_bits <= `TARB_RESET_BYTE;
    end else begin
      headroom_bits <= headroom_d;
    end
  end

  // ready flag copy, one cycle behind the status bit
  always_ff @(posedge clk) begin
    if (srst) begin
      aux_ready <= 1'b0;
    end else begin
      aux_ready <= ready_q;
    end
  end

  // framed or raw coder output
  always_ff @(posedge clk) begin
    if (srst) begin
      framed_output_on <= 1'b0;
    end else begin
      framed_output_on <= setup_q[`TARB_FRAMED_BIT];
    end
  end

  // stereo or mono coding
  always_ff @(posedge clk) begin
    if (srst) begin
      stereo_coding_on <= 1'b0;
    end else begin
      stereo_coding_on <= setup_q[`TARB_STEREO_BIT];
    end
  end

  // coder algorithm choice
  always_ff @(posedge clk) begin
    if (srst) begin
      codec_select <= TARB_CODEC_ADAPTIVE;
    end else begin
      codec_select <= tarb_codec_type'(setup_q[`TARB_CODEC_HI_BIT:`TARB_CODEC_LO_BIT]);
    end
  end

  // read data straight from its flop
  assign reg_rdata = rdata_q;

endmodule : tarb_regs

`default_nettype wire

// File: testbench/tarb_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tarb_regs_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic aux_block_done,
  // settings and status
  input wire logic [15:0] treble_corner_bits,
  input wire logic [15:0] bass_corner_bits,
  input wire logic signed [7:0] bass_gain_bits,
  input wire logic [7:0] headroom_bits,
  input wire logic aux_ready,
  input wire logic framed_output_on,
  input wire logic stereo_coding_on,
  input wire tarb_pkg::tarb_codec_type codec_select
);
  import tarb_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // one byte written at a given address
  sequence wr_at(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  treble_lo_a:
    assert property (wr_at(8'h77) |-> ##2 treble_corner_bits[7:0] == $past(reg_wdata, 2))
    else $error("treble corner low byte wrong");
  bass_hi_a:
    assert property (wr_at(8'h7A) |-> ##2 bass_corner_bits[15:8] == $past(reg_wdata, 2))
    else $error("bass corner high byte wrong");
  bass_gain_a:
    assert property (wr_at(8'h7C) ##0 $signed(reg_wdata) inside {[-12:12]}
      |-> ##2 bass_gain_bits == $past(reg_wdata, 2))
    else $error("bass gain not applied");
  bass_clip_a:
    assert property (wr_at(8'h7C) ##0 $signed(reg_wdata) > 12 |-> ##2 bass_gain_bits == 8'sh0C)
    else $error("bass gain not limited");
  atten_clip_a:
    assert property (wr_at(8'h7D) ##0 reg_wdata > 8'h0C |-> ##2 headroom_bits == 8'h0C)
    else $error("headroom not limited");
  ready_set_a:
    assert property (aux_block_done |-> ##2 aux_ready)
    else $error("ready flag not raised");
  status_read_a:
    assert property (reg_rd && reg_addr == 8'hB6 |=> reg_rdata == {7'h00, aux_ready})
    else $error("status read differs from flag");
  setup_fields_a:
    assert property (wr_at(8'hB8) |-> ##2 ($past(reg_wdata, 2) & 8'h0F)
      == {4'h0, codec_select, stereo_coding_on, framed_output_on})
    else $error("coder setup fields wrong");
  bass_floor_a:
    assert property (wr_at(8'h7C) ##0 $signed(reg_wdata) < -12 |-> ##2 bass_gain_bits == 8'hF4)
    else $error("bass cut not limited");
  ready_clear_a:
    assert property (wr_at(8'hB6) ##0 !reg_wdata[0] && !aux_block_done |-> ##2 !aux_ready)
    else $error("ready flag not cleared");
endmodule : tarb_regs_monitor
bind tarb_regs tarb_regs_monitor i_mon (.clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .aux_block_done, .treble_corner_bits, .bass_corner_bits, .bass_gain_bits,
  .headroom_bits, .aux_ready, .framed_output_on, .stereo_coding_on, .codec_select);
`default_nettype wire

// File: testbench/tarb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tarb_host_model (
  // clock
  input wire logic clk,
  // register port toward the device
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // one write strobe; released lines show the inverse
  task wr(input logic [7:0] a, d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
  endtask : wr
  // read strobe; data taken once the answer settles
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b0, ~a};
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : tarb_host_model
`default_nettype wire

// File: testbench/tarb_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tarb_regs_tb;
  import tarb_pkg::*;
  logic clk, srst, reg_wr, reg_rd, aux_load, aux_block_done, aux_ready;
  logic framed_output_on, stereo_coding_on;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, aux_load_byte, headroom_bits, v, g;
  logic [5:0] aux_load_index;
  logic [15:0] aux_block_bits, treble_corner_bits, bass_corner_bits, tc, bc;
  logic signed [7:0] treble_gain_bits, bass_gain_bits;
  tarb_codec_type codec_select;
  logic [31:0] rnd = 32'h8EA49228;
  logic [7:0] gv [6] = '{8'h0C, 8'h0D, 8'hF4, 8'hF3, 8'h80, 8'h05};
  byte unsigned aux_q [$];
  int mismatches, tests_run, cyc;
  tarb_host_model h (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  tarb_regs i_dut (.clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .aux_load, .aux_load_index, .aux_load_byte, .aux_block_done, .aux_block_bits,
    .treble_corner_bits, .bass_corner_bits, .treble_gain_bits, .bass_gain_bits,
    .headroom_bits, .aux_ready, .framed_output_on, .stereo_coding_on, .codec_select);
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (++cyc == 5000) begin
    mismatches++;
    wrap_up();
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // saturated step count
  function automatic logic [7:0] clip(input int x, lo);
    return (x > 12) ? 8'h0C : (x < lo) ? 8'(lo) : 8'(x);
  endfunction : clip
  task chk(input string n, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task rdc(input logic [7:0] a, e);
    h.rd(a, v);
    chk("rdata", {8'h00, v}, {8'h00, e});
  endtask : rdc
  task wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    {srst, aux_load, aux_block_done, aux_load_index, aux_load_byte, aux_block_bits} = {1'b1, 32'h0};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int a = 'h77; a <= 'hB8; a++) rdc(8'(a), 8'h00);
    bc = 16'd21 + 16'(rnd % 729);
    tc = bc + 16'(rnd[31:21]);
    h.wr(8'h77, tc[7:0]);
    h.wr(8'h78, tc[15:8]);
    h.wr(8'h79, bc[7:0]);
    h.wr(8'h7A, bc[15:8]);
    @(posedge clk);
    #1 chk("treble corner", treble_corner_bits, tc);
    chk("bass corner", bass_corner_bits, bc);
    // gains at and beyond the limits, headroom first
    for (int i = 0; i < 8; i++) begin
      g = (i < 6) ? gv[i] : rnd[7:0];
      rnd = nxt(rnd);
      h.wr(8'h7B, 8'h00);
      h.wr(8'h7C, 8'h00);
      h.wr(8'h7D, g);
      h.wr(8'h7B, g);
      h.wr(8'h7C, ~g);
      @(posedge clk);
      #1 chk("headroom", 16'(headroom_bits), 16'(clip(g, 0)));
      chk("treble gain", 16'($unsigned(treble_gain_bits)), 16'(clip($signed(g), -12)));
      chk("bass gain", 16'($unsigned(bass_gain_bits)), 16'(clip($signed(~g), -12)));
    end
    // every coder, stereo only with the adaptive one
    for (int c = 0; c < 4; c++) begin
      g = {4'hF, 2'(c), c == 0, c[0]};
      h.wr(8'hB8, g);
      rdc(8'hB8, g & 8'h0F);
      chk("fields", 16'({codec_select, stereo_coding_on, framed_output_on}), 16'(g[3:0]));
    end
    // one full ancillary block from the decoder
    for (int i = 0; i < 56; i++) begin
      rnd = nxt(rnd);
      aux_q.push_back(rnd[7:0]);
      @(posedge clk);
      {aux_load, aux_load_index, aux_load_byte} <= {1'b1, 6'(i), rnd[7:0]};
    end
    @(posedge clk);
    {aux_load, aux_block_done, aux_block_bits} <= {2'b01, rnd[31:16]};
    @(posedge clk);
    aux_block_done <= 1'b0;
    h.wr(8'h7E, 8'h5A);
    chk("ready", 16'(aux_ready), 16'h1);
    rdc(8'hB6, 8'h01);
    foreach (aux_q[i]) rdc(8'h7E + 8'(i), aux_q[i]);
    rdc(8'hF0, rnd[23:16]);
    rdc(8'hF1, rnd[31:24]);
    h.wr(8'hB6, 8'h00);
    rdc(8'hB6, 8'h00);
    chk("ready", 16'(aux_ready), 16'h0);
    // a second reset in mid-run clears settings and buffer
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk("reset corners", treble_corner_bits | bass_corner_bits, 16'h0000);
    rdc(8'h7E, 8'h00);
    wrap_up();
  end
endmodule : tarb_regs_tb
`default_nettype wire
